// ### hdl/tmr_pkg.sv
`default_nettype none
// ==========================================================
// shared constants of the result bank
package tmr_pkg;
  localparam int CLK_FREQ_MHZ   = 40;
  localparam int TIMEBASE_MHZ   = 16;
  localparam int TAP_SPACING_NS = 250;
  // least time, rounded up to whole cycles
  localparam int TAP_CYCLES =
    (TAP_SPACING_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int NUM_TAPS    = 4;
  localparam int NUM_RESULTS = 9;
  localparam int AVG_SHIFT   = 3;

  localparam logic [5:0] TAP_LAST   = 6'(TAP_CYCLES * NUM_TAPS);
  localparam logic [5:0] PHASE_INC  = 6'(TIMEBASE_MHZ);
  localparam logic [5:0] PHASE_MOD  = 6'(CLK_FREQ_MHZ);
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // register addresses
  localparam logic [7:0] ADDR_CORR_MAG_AT_PEAK    = 8'h77;
  localparam logic [7:0] ADDR_CORR_MAG_PLUS_250NS = 8'h78;
  localparam logic [7:0] ADDR_CORR_MAG_PLUS_500NS = 8'h79;
  localparam logic [7:0] ADDR_CORR_MAG_PLUS_750NS = 8'h7a;
  localparam logic [7:0] ADDR_CORR_MAG_PLUS_1000NS = 8'h7b;
  localparam logic [7:0] ADDR_FREQ_OFFSET_ESTIMATE = 8'h7c;
  localparam logic [7:0] ADDR_FLIGHT_COUNT_LOW    = 8'h7d;
  localparam logic [7:0] ADDR_FLIGHT_COUNT_MID    = 8'h7e;
  localparam logic [7:0] ADDR_FLIGHT_COUNT_HIGH   = 8'h7f;

  // result slots, in address order
  localparam int IDX_PEAK       = 0;
  localparam int IDX_OFFSET     = 5;
  localparam int IDX_COUNT_LOW  = 6;
  localparam int IDX_COUNT_MID  = 7;
  localparam int IDX_COUNT_HIGH = 8;
endpackage
`default_nettype wire

// ### hdl/tmr_result_byte.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// one read-only result byte, loaded by the measurement logic
module tmr_result_byte (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // load side
  input  wire logic       load,
  input  wire logic [7:0] d,
  // stored value
  output logic      [7:0] q
);
  logic [7:0] next_q;

  always_comb begin
    next_q = load ? d : q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= tmr_pkg::RESET_BYTE; // see RULE3
    end else begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// ### hdl/tmr_results.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1: peak correlator magnitude is captured in its own read-only byte.
// RULE2: four more magnitudes taken 250, 500, 750, 1000 ns after the peak.
// RULE3: every result byte is a full byte, zero after reset; all but the signed frequency offset are unsigned.
// RULE4: frequency offset is signed two's complement, spanning -90 to +90 deg.
// RULE5: frequency offset gets a first estimate when the PHY header is seen.
// RULE6: offset is averaged over the frame and stored at frame end.
// RULE7: flight time counts periods of a 16 MHz timebase.
// RULE8: flight count bits 7:0 read at their own address.
// RULE9: flight count bits 15:8 read at the next address.
// RULE10: flight count bits 23:16 read at the address after that.
// RULE11: results read back only while the measurement mode is enabled.
// RULE12: all flight count bytes are loaded from one counter sample.
module tmr_results (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // mode control
  input  wire logic       flight_measure_mode_enable,
  // correlator
  input  wire logic [7:0] corr_mag,
  input  wire logic       corr_peak,
  // frequency estimator
  input  wire logic [7:0] freq_sample,
  input  wire logic       freq_sample_valid,
  input  wire logic       phr_detected,
  input  wire logic       frame_end,
  // flight timer
  input  wire logic       flight_start,
  input  wire logic       flight_stop,
  // register read port
  input  wire logic       rd_en,
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data,
  output logic            rd_valid
);
  localparam int N = tmr_pkg::NUM_RESULTS;

  logic [7:0]  slot_q   [N];
  logic [7:0]  slot_d   [N];
  logic        slot_load[N];

  logic        tap_run;
  logic [5:0]  tap_cnt;
  logic        next_tap_run;
  logic [5:0]  next_tap_cnt;

  logic signed [7:0] offset_avg;
  logic signed [7:0] next_offset_avg;
  logic signed [8:0] offset_diff;

  logic        cnt_run;
  logic [5:0]  phase;
  logic [23:0] flight_cnt;
  logic        next_cnt_run;
  logic [5:0]  next_phase;
  logic [6:0]  phase_sum;
  logic [23:0] next_flight_cnt;

  logic [7:0]  rd_offset;
  logic        rd_hit;
  logic [7:0]  next_rd_data;

  // ========================================================
  // result storage
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_slot
      tmr_result_byte u_byte (
        .clk   (clk),
        .rst_b (rst_b),
        .load  (slot_load[g]),
        .d     (slot_d[g]),
        .q     (slot_q[g])
      );
    end
  endgenerate

  // ========================================================
  // correlator tap sampling
  always_comb begin
    next_tap_run = tap_run;
    next_tap_cnt = tap_cnt;
    if (corr_peak) begin
      next_tap_run = 1'b1;
      next_tap_cnt = 6'h01;
    end else if (tap_run) begin
      next_tap_cnt = tap_cnt + 6'h01;
      if (tap_cnt == tmr_pkg::TAP_LAST) begin
        next_tap_run = 1'b0;
        next_tap_cnt = 6'h00;
      end
    end
  end

  // ========================================================
  // tap sampling registers
  // a new peak restarts the taps and drops any still pending
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tap_run <= 1'b0;
      tap_cnt <= 6'h00;
    end else begin
      tap_run <= next_tap_run;
      tap_cnt <= next_tap_cnt;
    end
  end

  // ========================================================
  // frequency offset averaging
  always_comb begin
    // both sides sign-extended so a lower sample pulls the average down
    offset_diff     = {freq_sample[7], freq_sample} -
                      {offset_avg[7], offset_avg};
    next_offset_avg = offset_avg;
    if (phr_detected) begin
      next_offset_avg = freq_sample; // see RULE5
    end else if (freq_sample_valid) begin
      next_offset_avg = offset_avg +
                        8'(offset_diff >>> tmr_pkg::AVG_SHIFT); // see RULE6
    end
  end

  // ========================================================
  // offset average register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      offset_avg <= 8'sh00;
    end else begin
      offset_avg <= next_offset_avg;
    end
  end

  // ========================================================
  // flight timer on a 16 MHz tick derived from 40 MHz
  always_comb begin
    next_cnt_run    = cnt_run;
    next_flight_cnt = flight_cnt;
    phase_sum       = 7'(phase) + 7'(tmr_pkg::PHASE_INC);
    next_phase      = phase_sum[5:0];
    if (phase_sum >= 7'(tmr_pkg::PHASE_MOD)) begin
      next_phase = 6'(phase_sum - 7'(tmr_pkg::PHASE_MOD));
      if (cnt_run) begin
        next_flight_cnt = flight_cnt + 24'h000001; // see RULE7
      end
    end
    if (flight_start) begin
      next_cnt_run    = 1'b1;
      next_phase      = 6'h00;
      next_flight_cnt = 24'h000000;
    end else if (flight_stop) begin
      next_cnt_run = 1'b0;
    end
  end

  // ========================================================
  // flight timer registers
  // phase restarts with the count so every run starts on a whole tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_run    <= 1'b0;
      phase      <= 6'h00;
      flight_cnt <= 24'h000000;
    end else begin
      cnt_run    <= next_cnt_run;
      phase      <= next_phase;
      flight_cnt <= next_flight_cnt;
    end
  end

  // ========================================================
  // slot loads
  always_comb begin
    for (int i = 0; i < N; i++) begin
      slot_load[i] = 1'b0;
      slot_d[i]    = corr_mag;
    end
    slot_load[tmr_pkg::IDX_PEAK] = corr_peak; // see RULE1
    for (int k = 1; k <= tmr_pkg::NUM_TAPS; k++) begin
      if (tap_run && tap_cnt == 6'(tmr_pkg::TAP_CYCLES * k)) begin
        slot_load[tmr_pkg::IDX_PEAK + k] = 1'b1; // see RULE2
      end
    end
    // signed value, full scale is +-90 deg
    slot_d[tmr_pkg::IDX_OFFSET]    = next_offset_avg; // see RULE4
    slot_load[tmr_pkg::IDX_OFFSET] = phr_detected | frame_end; // see RULE5
    // a stop with the counter idle keeps the old snapshot
    if (cnt_run && flight_stop) begin
      slot_load[tmr_pkg::IDX_COUNT_LOW]  = 1'b1; // see RULE12
      slot_load[tmr_pkg::IDX_COUNT_MID]  = 1'b1; // see RULE12
      slot_load[tmr_pkg::IDX_COUNT_HIGH] = 1'b1; // see RULE12
    end
    slot_d[tmr_pkg::IDX_COUNT_LOW]  = flight_cnt[7:0];   // see RULE8
    slot_d[tmr_pkg::IDX_COUNT_MID]  = flight_cnt[15:8];  // see RULE9
    slot_d[tmr_pkg::IDX_COUNT_HIGH] = flight_cnt[23:16]; // see RULE10
  end

  // ========================================================
  // register read decode
  always_comb begin
    rd_offset    = rd_addr - tmr_pkg::ADDR_CORR_MAG_AT_PEAK;
    rd_hit       = flight_measure_mode_enable && // see RULE11
                   rd_addr >= tmr_pkg::ADDR_CORR_MAG_AT_PEAK &&
                   rd_addr <= tmr_pkg::ADDR_FLIGHT_COUNT_HIGH;
    next_rd_data = tmr_pkg::RESET_BYTE;
    if (rd_en && rd_hit) begin
      next_rd_data = slot_q[rd_offset[3:0]];
    end
  end

  // ========================================================
  // read port registers
  // misses answer zero so no stale result leaks out
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data  <= tmr_pkg::RESET_BYTE;
      rd_valid <= 1'b0;
    end else begin
      rd_data  <= next_rd_data;
      rd_valid <= rd_en;
    end
  end
endmodule
`default_nettype wire

// ### test/tmr_results_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker of the result bank
module tmr_results_checker (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // mode control
  input  wire logic       flight_measure_mode_enable,
  // correlator
  input  wire logic [7:0] corr_mag,
  input  wire logic       corr_peak,
  // frequency estimator
  input  wire logic [7:0] freq_sample,
  input  wire logic       freq_sample_valid,
  input  wire logic       phr_detected,
  input  wire logic       frame_end,
  // flight timer
  input  wire logic       flight_start,
  input  wire logic       flight_stop,
  // register read port
  input  wire logic       rd_en,
  input  wire logic [7:0] rd_addr,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic md = flight_measure_mode_enable;
  rd_valid_a:
    assert property (1 |=> rd_valid == $past(rd_en)) else $error("bad valid");
  idle_zero_a:
    assert property (!rd_en |=> rd_data == 8'h00) else $error("idle data");
  mode_off_a:
    assert property (!md |=> rd_data == 8'h00) else $error("mode off data");
  miss_zero_a:
    assert property (rd_en && !(rd_addr inside {[8'h77:8'h7f]})
      |=> rd_data == 8'h00) else $error("miss data");
  peak_read_a:
    assert property (corr_peak ##1 (rd_en && md && rd_addr == 8'h77)
      |=> rd_data == $past(corr_mag, 2)) else $error("peak value");
  tap_read_a:
    assert property (corr_peak ##1 (!corr_peak throughout (1'b1 ##30
      (rd_en && md && rd_addr == 8'h7a))) |=> rd_data == $past(corr_mag, 2))
      else $error("tap value");
  offset_first_a:
    assert property (phr_detected ##1 (rd_en && md && rd_addr == 8'h7c)
      |=> rd_data == $past(freq_sample, 2)) else $error("first offset");
  count_hold_a:
    assert property (rd_en && md && rd_addr == 8'h7e && !flight_stop ##1
      (rd_en && md && rd_addr == 8'h7e) |=> $stable(rd_data))
      else $error("count byte moved");
  cover property (corr_peak ##40 rd_en);
  cover property (phr_detected ##[1:20] frame_end);
  cover property (flight_start ##[700:800] flight_stop);
endmodule
bind tmr_results tmr_results_checker u_chk (
  .clk                        (clk),
  .rst_b                      (rst_b),
  .flight_measure_mode_enable (flight_measure_mode_enable),
  .corr_mag                   (corr_mag),
  .corr_peak                  (corr_peak),
  .freq_sample                (freq_sample),
  .freq_sample_valid          (freq_sample_valid),
  .phr_detected               (phr_detected),
  .frame_end                  (frame_end),
  .flight_start               (flight_start),
  .flight_stop                (flight_stop),
  .rd_en                      (rd_en),
  .rd_addr                    (rd_addr),
  .rd_data                    (rd_data),
  .rd_valid                   (rd_valid)
);
`default_nettype wire

// ### test/test_tmr_results.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// read-back tests of the result bank
module test_tmr_results;
  logic       clk = 0, rst_b = 0, flight_measure_mode_enable = 1;
  logic       corr_peak = 0, freq_sample_valid = 0, phr_detected = 0;
  logic       frame_end = 0, flight_start = 0, flight_stop = 0, rd_en = 0;
  logic       rd_valid;
  logic [7:0] corr_mag = 0, freq_sample = 0, rd_addr = 0, rd_data, a;
  logic [7:0] exp_q [9] = '{default: 8'h00};
  int         failures = 0, n_tests = 0, cyc = 0;
  always #12.5 clk = ~clk;
  tmr_results dut (
    .clk                        (clk),
    .rst_b                      (rst_b),
    .flight_measure_mode_enable (flight_measure_mode_enable),
    .corr_mag                   (corr_mag),
    .corr_peak                  (corr_peak),
    .freq_sample                (freq_sample),
    .freq_sample_valid          (freq_sample_valid),
    .phr_detected               (phr_detected),
    .frame_end                  (frame_end),
    .flight_start               (flight_start),
    .flight_stop                (flight_stop),
    .rd_en                      (rd_en),
    .rd_addr                    (rd_addr),
    .rd_data                    (rd_data),
    .rd_valid                   (rd_valid)
  );
  task automatic complete_run;
    if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    n_tests++;
    if (got !== want) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic step;
    @(negedge clk);
  endtask
  // ==========================================================
  // all slots back to back, two repeat reads of 0x7e, then a miss
  task automatic burst;
    logic [7:0] want;
    for (int i = 0; i <= 12; i++) begin
      step;
      if (i > 0) begin
        want = (flight_measure_mode_enable && a inside {[8'h77:8'h7f]})
               ? exp_q[a - 8'h77] : 8'h00;
        chk({7'h0, rd_valid}, 8'h01);
        chk(rd_data, want);
      end
      rd_addr = i < 9 ? 8'h77 + 8'(i) : (i < 11 ? 8'h7e : 8'h76);
      a = rd_addr;
      rd_en = i < 12;
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      complete_run;
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) step;
    rst_b = 1;
    burst;
    step;
    corr_peak = 1;
    corr_mag = 8'h80;
    exp_q[0] = 8'h80;
    for (int k = 1; k <= 40; k++) begin
      step;
      corr_peak = 0;
      corr_mag = 8'hff - 8'(k);
      rd_en = 1;
      rd_addr = 8'h77 + 8'(k / 10);
      if (k % 10 == 0) exp_q[k / 10] = corr_mag;
    end
    burst;
    step;
    phr_detected = 1;
    freq_sample = 8'hb5;
    step;
    phr_detected = 0;
    freq_sample = 8'hdd;
    rd_en = 1;
    rd_addr = 8'h7c;
    step;
    rd_en = 0;
    chk(rd_data, 8'hb5);
    freq_sample_valid = 1;
    frame_end = 1;
    step;
    freq_sample_valid = 0;
    frame_end = 0;
    flight_start = 1;
    exp_q[5] = 8'hba;
    step;
    flight_start = 0;
    repeat (750) step;
    flight_stop = 1;
    exp_q[6] = 8'h2c;
    exp_q[7] = 8'h01;
    step;
    flight_stop = 0;
    burst;
    flight_measure_mode_enable = 0;
    burst;
    complete_run;
  end
endmodule
`default_nettype wire
